// file: pdcu_defines.vh
// constants for the four-channel duty compare unit
// assumes a shared 12-bit time base outside this block
`ifndef PDCU_DEFINES_VH
`define PDCU_DEFINES_VH

`define PDCU_CHANNELS 4
`define PDCU_DUTY_W 14
`define PDCU_CNT_W 12
`define PDCU_PHASE_W 2

// time base mode select codes
`define PDCU_MODE_FREE 2'h0
`define PDCU_MODE_SINGLE 2'h1
`define PDCU_MODE_UPDN 2'h2
`define PDCU_MODE_UPDN_DBL 2'h3

// prescale select for 1:1
`define PDCU_PRESCALE_1TO1 2'h0

// register indices on the plain port
`define PDCU_REG_DUTY0_LOW 4'h0
`define PDCU_REG_DUTY0_HIGH 4'h1
`define PDCU_REG_DUTY1_LOW 4'h2
`define PDCU_REG_DUTY1_HIGH 4'h3
`define PDCU_REG_DUTY2_LOW 4'h4
`define PDCU_REG_DUTY2_HIGH 4'h5
`define PDCU_REG_DUTY3_LOW 4'h6
`define PDCU_REG_DUTY3_HIGH 4'h7
`define PDCU_REG_STATUS 4'h8
`define PDCU_ADDR_W 4

`define PDCU_DUTY_RESET 14'h0000
`define PDCU_BYTE_W 8
`define PDCU_HIGH_BITS 6

`endif

// file: pdcu_duty_compare.v
// four double-buffered duty compare channels with complementary outputs
// assumes time base count, direction, period, phase and enable come from
// logic on the same clock; software uses the plain register port
`timescale 1ns/1ps
`include "pdcu_defines.vh"

// How it works
// - four 14-bit duty values built from low byte and six high bits
// - upper 12 duty bits compared to count; low 2 bits pick phase
// - at 1:1 prescale match needs count equal and phase equal
// - other prescales match on first phase, low duty bits ignored
// - software buffer separate from active compare register per channel
// - edge-aligned modes load active duty when count wraps to zero
// - time base disabled loads every buffer continuously unless update disable is set
// - plain up/down mode loads when count zero, direction flag not checked
// - double-update mode loads at count zero and at period match
// - free-running and single-shot modes give edge-aligned output
// - edge-aligned output active at count zero, inactive on duty match
// - edge duty zero never active; duty above period always active
// - both up/down modes give center-aligned output
// - center match sets active counting down, inactive counting up
// - center duty zero never active; duty at or above period always
// - center start preloads period and counts down, done by time base
// - up/down period is twice the period value, set by time base
// - channel n drives pair n, main odd, complement even
// - pair outputs always opposite; dead interval left to later stage
// - override stage may replace waveform, keeping complement relation
// - mode select 00 free, 01 single, 10 up/down, 11 double
// - update disable blocks every buffer to active transfer
// - period value is 12 bits wide
// note: the time base flag may still read down while the count sits at zero
module pdcu_duty_compare #(
  parameter CHANNELS = `PDCU_CHANNELS,
  parameter DUTY_W = `PDCU_DUTY_W,
  parameter CNT_W = `PDCU_CNT_W
) (
  input wire clk,
  input wire rst,
  input wire [`PDCU_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  input wire [CNT_W-1:0] timeBaseCount,
  input wire countDirectionFlag,
  input wire [CNT_W-1:0] periodValue,
  input wire timeBaseEnable,
  input wire [1:0] timeBasePrescaleSelect,
  input wire [1:0] timeBaseModeSelect,
  input wire updateDisable,
  input wire [1:0] quadPhase,
  input wire [3:0] overrideEnable,
  input wire [3:0] overrideValue,
  output reg pair0MainOut,
  output reg pair0ComplementOut,
  output reg pair1MainOut,
  output reg pair1ComplementOut,
  output reg pair2MainOut,
  output reg pair2ComplementOut,
  output reg pair3MainOut,
  output reg pair3ComplementOut
);

  // ***********************************************************
  // functions
  // ***********************************************************
  // match test shared by all channels
  function dutyMatch;
    input [DUTY_W-1:0] duty;
    input [CNT_W-1:0] count;
    input [1:0] phase;
    input [1:0] prescale;
    begin
      if (prescale == `PDCU_PRESCALE_1TO1) begin
        dutyMatch = (duty[DUTY_W-1:2] == count) &&
                    (duty[1:0] == phase);
      end else begin
        dutyMatch = (duty[DUTY_W-1:2] == count) &&
                    (phase == 2'h0);
      end
    end
  endfunction

  // ***********************************************************
  // storage
  // ***********************************************************
  reg [DUTY_W-1:0] dutyBuffer [0:CHANNELS-1];
  reg [DUTY_W-1:0] dutyActive [0:CHANNELS-1];
  reg [CHANNELS-1:0] compareOut;
  reg [CNT_W-1:0] countPrev;
  reg runPrev;

  wire centerMode;
  wire periodMatch;
  wire countZero;
  wire freshStep;
  reg loadNow;
  integer i;

  // up/down period of twice the period value comes from the time base
  assign centerMode = timeBaseModeSelect[1];
  assign periodMatch = (timeBaseCount == periodValue);
  assign countZero = (timeBaseCount == {CNT_W{1'b0}});
  // count value just arrived: edges act once per count, on first phase
  assign freshStep = (quadPhase == 2'h0) &&
                     (!runPrev || timeBaseCount != countPrev);

  // ***********************************************************
  // transfer decision
  // ***********************************************************
  always @* begin
    loadNow = 1'b0;
    if (!timeBaseEnable) begin
      loadNow = 1'b1;
    end else if (freshStep) begin
      case (timeBaseModeSelect)
        `PDCU_MODE_FREE,
        `PDCU_MODE_SINGLE: begin
          loadNow = countZero && runPrev;
        end
        `PDCU_MODE_UPDN: begin
          // zero is only reached at the bottom turn, where upward begins
          loadNow = countZero;
        end
        `PDCU_MODE_UPDN_DBL: begin
          loadNow = countZero || periodMatch;
        end
        default: begin
          loadNow = 1'b0;
        end
      endcase
    end
    if (updateDisable) begin
      loadNow = 1'b0;
    end
  end

  // ***********************************************************
  // registers and compare
  // ***********************************************************
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        dutyBuffer[i] <= `PDCU_DUTY_RESET;
        dutyActive[i] <= `PDCU_DUTY_RESET;
      end
      compareOut <= {CHANNELS{1'b0}};
      countPrev <= {CNT_W{1'b0}};
      runPrev <= 1'b0;
      regReadData <= 8'h00;
    end else begin
      countPrev <= timeBaseCount;
      runPrev <= timeBaseEnable;
      regReadData <= 8'h00;
      if (regWrite && !regAddr[3]) begin
        if (regAddr[0]) begin
          dutyBuffer[regAddr[2:1]][DUTY_W-1:`PDCU_BYTE_W] <=
            regWriteData[`PDCU_HIGH_BITS-1:0];
        end else begin
          dutyBuffer[regAddr[2:1]][`PDCU_BYTE_W-1:0] <=
            regWriteData;
        end
      end
      if (regRead) begin
        if (!regAddr[3]) begin
          regReadData <= regAddr[0] ?
            {2'h0, dutyBuffer[regAddr[2:1]][DUTY_W-1:`PDCU_BYTE_W]} :
            dutyBuffer[regAddr[2:1]][`PDCU_BYTE_W-1:0];
        end else if (regAddr == `PDCU_REG_STATUS) begin
          regReadData <= {4'h0, compareOut};
        end
      end
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (loadNow) begin
          dutyActive[i] <= dutyBuffer[i];
        end
        if (!timeBaseEnable) begin
          compareOut[i] <= 1'b0;
        end else if (dutyActive[i] == `PDCU_DUTY_RESET) begin
          compareOut[i] <= 1'b0;
        end else if (!centerMode) begin
          // edge aligned
          if (dutyActive[i][DUTY_W-1:2] > periodValue) begin
            compareOut[i] <= 1'b1;
          end else if (dutyMatch(dutyActive[i], timeBaseCount,
                                 quadPhase, timeBasePrescaleSelect)) begin
            compareOut[i] <= 1'b0;
          end else if (countZero && freshStep) begin
            compareOut[i] <= 1'b1;
          end
        end else begin
          // start from period counting down: no output set before a down match
          if (dutyActive[i][DUTY_W-1:2] >= periodValue) begin
            compareOut[i] <= 1'b1;
          end else if (dutyMatch(dutyActive[i], timeBaseCount,
                                 quadPhase, timeBasePrescaleSelect)) begin
            compareOut[i] <= countDirectionFlag;
          end
        end
      end
    end
  end

  // ***********************************************************
  // output pairs
  // ***********************************************************
  reg [CHANNELS-1:0] mainWave;
  integer j;

  always @* begin
    for (j = 0; j < CHANNELS; j = j + 1) begin
      mainWave[j] = overrideEnable[j] ? overrideValue[j] :
                    compareOut[j];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pair0MainOut <= 1'b0;
      pair0ComplementOut <= 1'b1;
      pair1MainOut <= 1'b0;
      pair1ComplementOut <= 1'b1;
      pair2MainOut <= 1'b0;
      pair2ComplementOut <= 1'b1;
      pair3MainOut <= 1'b0;
      pair3ComplementOut <= 1'b1;
    end else begin
      pair0MainOut <= mainWave[0];
      pair0ComplementOut <= ~mainWave[0];
      pair1MainOut <= mainWave[1];
      pair1ComplementOut <= ~mainWave[1];
      pair2MainOut <= mainWave[2];
      pair2ComplementOut <= ~mainWave[2];
      pair3MainOut <= mainWave[3];
      pair3ComplementOut <= ~mainWave[3];
    end
  end

endmodule // pdcu_duty_compare

// file: pdcu_duty_compare_asserts.sv
// assertions on the duty compare unit ports
// assumes the override inputs are low while the status register is read
`timescale 1ns/1ps
module pdcu_duty_compare_asserts (
  input wire clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire regRead,
  input wire [7:0] regReadData,
  input wire timeBaseEnable,
  input wire [3:0] overrideEnable,
  input wire pair0MainOut,
  input wire pair0ComplementOut,
  input wire pair1MainOut,
  input wire pair1ComplementOut,
  input wire pair2MainOut,
  input wire pair2ComplementOut,
  input wire pair3MainOut,
  input wire pair3ComplementOut
);
  wire [3:0] mainOut = {pair3MainOut, pair2MainOut, pair1MainOut, pair0MainOut};
  wire [3:0] compOut = {pair3ComplementOut, pair2ComplementOut,
    pair1ComplementOut, pair0ComplementOut};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle2;
    (!timeBaseEnable && overrideEnable == 4'h0) [*2];
  endsequence
  pair_opposite_a: assert property ((mainOut ^ compOut) == 4'hf)
    else $error("pair outputs not opposite");
  idle_low_a: assert property (s_idle2 |=> mainOut == 4'h0)
    else $error("output active while disabled");
  reset_pins_a: assert property (disable iff (1'b0)
    rst |=> mainOut == 4'h0 && compOut == 4'hf) else $error("reset pins");
  reset_read_a: assert property (disable iff (1'b0)
    rst |=> regReadData == 8'h00) else $error("reset read data");
  read_idle_a: assert property (!regRead |=> regReadData == 8'h00)
    else $error("read data without strobe");
  high_bits_a: assert property (regRead && regAddr < 4'h8 && regAddr[0]
    |=> regReadData[7:6] == 2'h0) else $error("high byte spare bits");
  unmapped_a: assert property (regRead && regAddr > 4'h8
    |=> regReadData == 8'h00) else $error("unmapped read not zero");
  status_pins_a: assert property (regRead && regAddr == 4'h8
    |=> regReadData == {4'h0, mainOut}) else $error("status vs pins");
endmodule // pdcu_duty_compare_asserts

bind pdcu_duty_compare pdcu_duty_compare_asserts i_asserts (.clk(clk),
  .rst(rst), .regAddr(regAddr), .regRead(regRead),
  .regReadData(regReadData), .timeBaseEnable(timeBaseEnable),
  .overrideEnable(overrideEnable), .pair0MainOut(pair0MainOut),
  .pair0ComplementOut(pair0ComplementOut), .pair1MainOut(pair1MainOut),
  .pair1ComplementOut(pair1ComplementOut), .pair2MainOut(pair2MainOut),
  .pair2ComplementOut(pair2ComplementOut), .pair3MainOut(pair3MainOut),
  .pair3ComplementOut(pair3ComplementOut));

// file: pdcu_gate_model.sv
// four half-bridge gate drivers behind the pair outputs
// assumes main outputs on upper switches, complements on lower
`timescale 1ns/1ps
module pdcu_gate_model (
  input wire clk,
  input wire [3:0] upperGate,
  input wire [3:0] lowerGate,
  output logic shootThrough
);
  initial shootThrough = 1'b0;
  // both switches of one leg on shorts the supply
  always @(posedge clk) if ((upperGate & lowerGate) != 4'h0) shootThrough <= 1'b1;
endmodule // pdcu_gate_model

// file: pdcu_duty_compare_tb.sv
// self-checking bench for the duty compare unit
// assumes the bench plays the time base; override on only in the last test
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module pdcu_duty_compare_tb;
  logic clk = 0, rst = 1, regWrite = 0, regRead = 0, dir = 0, ena = 0, update_disable = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [11:0] cnt = 0, per = 12'h00a;
  logic [1:0] phase = 0, mode = 0;
  wire [7:0] rdata;
  wire [3:0] mainOut, compOut;
  wire shoot;
  int failures = 0, cmp_count = 0, cycles = 0;
  logic [7:0] expQ[$];
  logic [7:0] expNow = 0;
  logic [3:0] ovrEn = 0, ovrVal = 0;
  logic pend = 0;
  always #2 clk = ~clk;
  pdcu_duty_compare i_pdcu_duty_compare (.clk(clk), .rst(rst), .regAddr(addr),
    .regWriteData(wdata), .regWrite(regWrite), .regRead(regRead),
    .regReadData(rdata), .timeBaseCount(cnt), .countDirectionFlag(dir),
    .periodValue(per), .timeBaseEnable(ena), .timeBasePrescaleSelect(2'h0),
    .timeBaseModeSelect(mode), .updateDisable(update_disable), .quadPhase(phase),
    .overrideEnable(ovrEn), .overrideValue(ovrVal),
    .pair0MainOut(mainOut[0]), .pair0ComplementOut(compOut[0]),
    .pair1MainOut(mainOut[1]), .pair1ComplementOut(compOut[1]),
    .pair2MainOut(mainOut[2]), .pair2ComplementOut(compOut[2]),
    .pair3MainOut(mainOut[3]), .pair3ComplementOut(compOut[3]));
  pdcu_gate_model i_pdcu_gate_model (.clk(clk), .upperGate(mainOut),
    .lowerGate(compOut), .shootThrough(shoot));
  // time base: count moves once per four phases
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (ena && phase == 2'h3) begin
      if (!mode[1]) cnt <= (cnt == per) ? 12'h0 : cnt + 12'h1;
      else if (dir ? cnt == 12'h0 : cnt == per) begin
        dir <= !dir;
        cnt <= dir ? 12'h1 : per - 12'h1;
      end else cnt <= dir ? cnt - 12'h1 : cnt + 12'h1;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      wrap_up();
    end
    if (pend) begin
      expNow = expQ.pop_front();
      `CHK(rdata, expNow)
    end
    pend <= regRead;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; regWrite <= 1;
    @(posedge clk); regWrite <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; regRead <= 1; expQ.push_back(e);
    @(posedge clk); regRead <= 0;
  endtask
  task automatic setd(input int ch, input logic [13:0] d);
    wr(4'(2 * ch), d[7:0]);
    wr(4'(2 * ch + 1), {2'h0, d[13:8]});
  endtask
  task automatic at(input logic [11:0] c);
    repeat (400) begin
      @(posedge clk);
      if (cnt == c && phase == 2'h1) break;
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    logic [7:0] v;
    v = $urandom(32'h71f1);
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 9; i++) rd(4'(i), 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(4'(i), v);
      rd(4'(i), i[0] ? (v & 8'h3f) : v);
    end
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    $display("register test done");
    setd(0, 14'h0000);
    setd(1, 14'h0014);
    setd(2, 14'h002c);
    setd(3, 14'h000e);
    ena <= 1;
    at(per); at(2); rd(4'h8, 8'h0e);
    at(8); rd(4'h8, 8'h04);
    at(3); setd(1, 14'h0024);
    at(7); rd(4'h8, 8'h04);
    at(7); rd(4'h8, 8'h06);
    update_disable <= 1;
    setd(1, 14'h0014);
    at(per); at(7); rd(4'h8, 8'h06);
    update_disable <= 0;
    $display("edge test done");
    for (int m = 2; m < 4; m++) begin
      ena <= 0;
      wr(4'h2, 8'h14);
      mode <= 2'(m); cnt <= per; dir <= 1;
      @(posedge clk); ena <= 1;
      at(8); rd(4'h8, 8'h04);
      at(2); rd(4'h8, 8'h0e);
      at(8); wr(4'h2, 8'h24);
      at(7); rd(4'h8, m == 3 ? 8'h06 : 8'h04);
      at(7); rd(4'h8, 8'h06);
    end
    $display("center test done");
    ovrEn <= 4'hf; ovrVal <= 4'ha;
    repeat (3) @(posedge clk);
    `CHK(mainOut, 4'ha)
    `CHK(compOut, 4'h5)
    ovrEn <= 4'h0;
    $display("override test done");
    `CHK(shoot, 1'b0)
    wrap_up();
  end
endmodule // pdcu_duty_compare_tb
